// ### ncb_pkg.sv
// Package for the channel B oscillator preset register bank.
// Assumes a byte-addressed configuration port with 8-bit data, one clock.
package ncb_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_PHASE_P0  = 12'h244;
   localparam logic [11:0] OFS_FREQ_P1   = 12'h248;
   localparam logic [11:0] OFS_PHASE_P1  = 12'h24C;
   localparam logic [11:0] OFS_FREQ_P2   = 12'h250;
   localparam logic [11:0] OFS_PHASE_P2  = 12'h254;
   localparam logic [11:0] OFS_FREQ_P3   = 12'h258;
   localparam logic [11:0] OFS_PHASE_P3  = 12'h25C;
   localparam logic [11:0] OFS_STARTUP   = 12'h270;
   localparam logic [11:0] OFS_VARIANT   = 12'h297;
   // Spacing between presets
   localparam logic [11:0] PRESET_STRIDE = 12'h008;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int          STARTUP_DONE_BIT = 0;
   localparam logic [31:0] FREQ_RESET       = 32'hC0000000;
   localparam logic [15:0] PHASE_RESET      = 16'h0000;
   // Variant code value is arbitrary
   localparam logic [7:0]  VARIANT_DEFAULT  = 8'h00;
   // Startup sequence length in clock cycles
   localparam int          INIT_CYCLES      = 64;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] freq;
      logic [15:0] phase;
   } ncb_preset_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } ncb_req_t;

endpackage

// ### ncb_regs.sv
// Channel B oscillator preset registers, startup status, variant code.
// Assumes the SPI front end hands over byte requests on sys_clk.
module ncb_regs
   import ncb_pkg::*;
#(
   parameter logic [7:0] VARIANT_CODE = VARIANT_DEFAULT,
   parameter int         INIT_LEN     = INIT_CYCLES
)(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         srst,
   // Byte register port
   input  wire ncb_req_t     req,
   output logic [7:0]        rdata,
   output logic              rvalid,
   // Mode and oscillator outputs
   input  wire logic         interleave_mode,
   input  wire ncb_preset_t  chan_a_preset [4],
   output ncb_preset_t       chan_b_active [4],
   output logic              init_done
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] chan_b_phase [4];
   logic [31:0] chan_b_freq  [4];
   logic [$clog2(INIT_LEN+1)-1:0] init_cnt;
   logic [7:0]  next_rdata;

   // Decode helpers: index and byte lane within a preset group
   logic [11:0] rel;
   logic [1:0]  pidx;
   logic        is_freq;
   logic        in_bank;
   assign rel     = req.addr - OFS_PHASE_P0 + 12'h004;
   assign in_bank = (req.addr >= OFS_PHASE_P0) && (req.addr <= OFS_PHASE_P3 + 12'h001);
   assign pidx    = rel[4:3];
   assign is_freq = ~rel[2];

   // ----------------------------------------------------------------
   // Startup sequencer
   // ----------------------------------------------------------------
   // Counter stands in for internal calibration; flag sticks once set
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         init_cnt  <= '0;
         init_done <= 1'b0;
      end else if (init_cnt == INIT_LEN[$bits(init_cnt)-1:0]) begin
         init_done <= 1'b1;
      end else begin
         init_cnt  <= init_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Preset writes
   // ----------------------------------------------------------------
   // Writes are not blocked before startup; the host holds them off
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < 4; i++) begin
            chan_b_phase[i] <= PHASE_RESET;
            chan_b_freq[i]  <= FREQ_RESET;
         end
      end else if (req.wr && in_bank) begin
         if (is_freq && pidx != 2'd0)
            chan_b_freq[pidx][8*rel[1:0] +: 8] <= req.wdata;
         else if (!is_freq && rel[1] == 1'b0)
            chan_b_phase[pidx][8*rel[0] +: 8] <= req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped and reserved bytes read zero
   always_comb begin
      next_rdata = 8'h00;
      if (req.addr == OFS_STARTUP)
         next_rdata[STARTUP_DONE_BIT] = init_done;
      else if (req.addr == OFS_VARIANT)
         next_rdata = VARIANT_CODE;
      else if (in_bank && is_freq && pidx != 2'd0)
         next_rdata = chan_b_freq[pidx][8*rel[1:0] +: 8];
      else if (in_bank && !is_freq && rel[1] == 1'b0)
         next_rdata = chan_b_phase[pidx][8*rel[0] +: 8];
   end

   // Read data registered, valid one cycle after the request
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd)
            rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator selection
   // ----------------------------------------------------------------
   // Preset 0 frequency lives outside this bank; channel A copy stands in
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (interleave_mode)
            chan_b_active[i] = chan_a_preset[i];
         else
            chan_b_active[i] = '{freq:  (i == 0) ? chan_a_preset[0].freq : chan_b_freq[i],
                                 phase: chan_b_phase[i]};
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_phase_reset;
      @(posedge sys_clk) srst |=> chan_b_phase[0] == PHASE_RESET && chan_b_phase[3] == 16'h0000;
   endproperty
   a_phase_reset: assert property (p_phase_reset) else $error("phase not zero after reset");

   property p_freq_reset;
      @(posedge sys_clk) srst |=> chan_b_freq[1] == 32'hC0000000 && chan_b_freq[3] == 32'hC0000000;
   endproperty
   a_freq_reset: assert property (p_freq_reset) else $error("freq reset value wrong");

   property p_phase_write;
      @(posedge sys_clk) disable iff (srst)
         req.wr && req.addr == OFS_PHASE_P1 |=> chan_b_phase[1][7:0] == $past(req.wdata);
   endproperty
   a_phase_write: assert property (p_phase_write) else $error("phase write lost");

   property p_init_done;
      @(posedge sys_clk) disable iff (srst)
         $rose(init_done) |-> $past(init_cnt) == INIT_LEN[$bits(init_cnt)-1:0];
   endproperty
   a_init_done: assert property (p_init_done) else $error("startup flag early");

   property p_status_read;
      @(posedge sys_clk) disable iff (srst)
         req.rd && req.addr == OFS_STARTUP |=> rvalid && rdata == {7'h00, $past(init_done)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_variant_read;
      @(posedge sys_clk) disable iff (srst)
         req.rd && req.addr == OFS_VARIANT |=> rdata == VARIANT_CODE;
   endproperty
   a_variant_read: assert property (p_variant_read) else $error("variant read wrong");

   property p_interleave;
      @(posedge sys_clk) disable iff (srst)
         interleave_mode |-> chan_b_active[2] == chan_a_preset[2];
   endproperty
   a_interleave: assert property (p_interleave) else $error("chan B used in interleave");

   property p_freq_write;
      @(posedge sys_clk) disable iff (srst)
         req.wr && req.addr == OFS_FREQ_P2 + 12'h003 |=> chan_b_freq[2][31:24] == $past(req.wdata);
   endproperty
   a_freq_write: assert property (p_freq_write) else $error("freq write lost");

   // Remaining reset values, so every preset word is covered
   property p_phase_reset_mid;
      @(posedge sys_clk) srst |=> chan_b_phase[1] == PHASE_RESET && chan_b_phase[2] == PHASE_RESET;
   endproperty
   a_phase_reset_mid: assert property (p_phase_reset_mid) else $error("phase reset wrong");

   property p_freq_reset_mid;
      @(posedge sys_clk) srst |=> chan_b_freq[2] == FREQ_RESET;
   endproperty
   a_freq_reset_mid: assert property (p_freq_reset_mid) else $error("freq 2 reset wrong");

   // Byte lanes at both ends of the bank, plus the lowest frequency byte
   property p_phase0_write;
      @(posedge sys_clk) disable iff (srst)
         req.wr && req.addr == OFS_PHASE_P0 + 12'h001 |=> chan_b_phase[0][15:8] == $past(req.wdata);
   endproperty
   a_phase0_write: assert property (p_phase0_write) else $error("phase 0 write lost");

   property p_freq1_write;
      @(posedge sys_clk) disable iff (srst)
         req.wr && req.addr == OFS_FREQ_P1 |=> chan_b_freq[1][7:0] == $past(req.wdata);
   endproperty
   a_freq1_write: assert property (p_freq1_write) else $error("freq 1 write lost");

   property p_phase3_write;
      @(posedge sys_clk) disable iff (srst)
         req.wr && req.addr == OFS_PHASE_P3 + 12'h001 |=> chan_b_phase[3][15:8] == $past(req.wdata);
   endproperty
   a_phase3_write: assert property (p_phase3_write) else $error("phase 3 write lost");

   // Startup flag never drops without a reset
   property p_init_sticky;
      @(posedge sys_clk) disable iff (srst)
         init_done |=> init_done;
   endproperty
   a_init_sticky: assert property (p_init_sticky) else $error("startup flag dropped");

   // Read answer timing: exactly one cycle, never unasked
   property p_read_latency;
      @(posedge sys_clk) disable iff (srst)
         req.rd |=> rvalid;
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read answer missing");

   property p_rvalid_cause;
      @(posedge sys_clk) disable iff (srst)
         rvalid |-> $past(req.rd);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause) else $error("read answer unasked");

   // Reserved status bits read zero
   property p_status_reserved;
      @(posedge sys_clk) disable iff (srst)
         req.rd && req.addr == OFS_STARTUP |=> rdata[7:1] == 7'h00;
   endproperty
   a_status_reserved: assert property (p_status_reserved) else $error("reserved bits set");

   // Normal mode passes channel B preset 3 through
   property p_direct_path;
      @(posedge sys_clk) disable iff (srst)
         !interleave_mode |-> chan_b_active[3].freq == chan_b_freq[3]
                              && chan_b_active[3].phase == chan_b_phase[3];
   endproperty
   a_direct_path: assert property (p_direct_path) else $error("chan B preset not used");

endmodule

// ### ncb_host.sv
// Host model: byte reads and writes on the register port.
// Assumes the bench calls access() one request at a time.
module ncb_host
   import ncb_pkg::*;
(
   // Clock
   input  wire logic       sys_clk,
   // Register port
   output ncb_req_t        req,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // One request held for one edge; released bus shows inverted values
   task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d,
                         output logic ok, output logic [7:0] q);
      @(posedge sys_clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1;
      ok = w ? !rvalid : rvalid;  // Read answer comes exactly one cycle on
      q = rdata;
   endtask
endmodule

// ### ncb_regs_test.sv
// Self-checking bench for the channel B preset register bank.
// Assumes the ncb_host model as the only register master.
module ncb_regs_test;
   import ncb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] VCODE = 8'h5A;  // Arbitrary variant code
   logic        sys_clk, srst, rvalid, init_done, il_mode, ok;
   logic [7:0]  rdata, q;
   ncb_req_t    req;
   ncb_preset_t a_pre [4];
   ncb_preset_t b_act [4];
   logic [7:0]  mem [32];
   logic [31:0] lfsr;
   int          n_errors, checks, i, k;

   ncb_regs #(.VARIANT_CODE(VCODE), .INIT_LEN(4)) ncb_regs_inst (.sys_clk(sys_clk),
      .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid), .interleave_mode(il_mode),
      .chan_a_preset(a_pre), .chan_b_active(b_act), .init_done(init_done));
   ncb_host ncb_host_inst (.sys_clk(sys_clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   // ----------------------------------------------------------------
   // Expectation helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   // Bytes 240..25F: freq at +0..+3 of presets 1..3 only, phase at +4..+5 of each preset
   function automatic logic mapped(input int b);
      return (b >= 8) ? (b % 8 < 6) : (b == 4 || b == 5);
   endfunction
   function automatic logic [7:0] rst_byte(input int b);
      return (b >= 8 && b % 8 < 4) ? FREQ_RESET[8 * (b % 8) +: 8] : 8'h00;
   endfunction
   function automatic ncb_preset_t exp_b(input int n);
      return '{freq: {mem[8*n+3], mem[8*n+2], mem[8*n+1], mem[8*n]},
               phase: {mem[8*n+5], mem[8*n+4]}};
   endfunction
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      ncb_host_inst.access(1'b0, a, 8'h00, ok, q);
      chk("rvalid", 48'h1, {47'h0, ok});
      chk("rdata", {40'h0, e}, {40'h0, q});
   endtask
   task automatic end_of_test();
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Whole bank image read back, then status and variant
   task automatic rd_all();
      for (i = 0; i < 32; i++) rd(12'h240 + 12'(i), mem[i]);
      rd(OFS_STARTUP, 8'h01);
      rd(OFS_VARIANT, VCODE);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Main sequence
   initial begin
      srst = 1'b1;
      il_mode = 1'b0;
      foreach (a_pre[n]) a_pre[n] = '0;
      lfsr = 32'hB3493406;
      n_errors = 0;
      checks = 0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      // Bounded wait before any other access
      for (k = 0; k < 20 && init_done !== 1'b1; k++) @(posedge sys_clk);
      chk("init_done", 48'h1, {47'h0, init_done});
      if (init_done !== 1'b1) end_of_test();
      for (i = 0; i < 32; i++) mem[i] = rst_byte(i);
      rd_all();
      // Random bytes over mapped and unmapped slots, then read-only places
      repeat (48) begin
         lfsr = next_rand(lfsr);
         ncb_host_inst.access(1'b1, 12'h240 + {7'h0, lfsr[4:0]}, lfsr[15:8], ok, q);
         chk("no_rvalid", 48'h1, {47'h0, ok});
         if (mapped(int'(lfsr[4:0]))) mem[lfsr[4:0]] = lfsr[15:8];
      end
      ncb_host_inst.access(1'b1, OFS_STARTUP, 8'hFE, ok, q);
      ncb_host_inst.access(1'b1, OFS_VARIANT, ~VCODE, ok, q);
      rd_all();
      // Oscillator outputs in both modes, fresh channel A values each time
      for (k = 0; k < 2; k++) begin
         @(posedge sys_clk);
         il_mode <= k[0];
         for (i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            a_pre[i] <= {lfsr, lfsr[31:16] ^ 16'hA5C3};
         end
         @(posedge sys_clk);
         #1;
         for (i = 0; i < 4; i++)
            chk("chan_b_active", k[0] ? a_pre[i] : (i == 0 ?
                {a_pre[0].freq, exp_b(0).phase} : exp_b(i)), b_act[i]);
      end
      end_of_test();
   end
endmodule
